/* verilog/black_level_consts.svh */
// How it works
// RULE1: loop on: per-channel offset register is a signed adder on ADC samples.
// RULE2: loop off: DAC code is offset register high bits plus fine bits.
// RULE3: range bit halves offset DAC swing in both loop and manual modes.
// RULE4: reduced range gives one-eighth LSB per code step, default one-quarter.
// RULE5: loop measures black level and servos 10-bit DAC code toward zero error.
// RULE6: loop on: one measurement per line after the trailing sync edge.
// RULE7: coast-clamp bit clear: skip measurement on lines where the PLL coasts.
// RULE8: after the trailing edge, count pixels to start value, then measure.
// RULE9: average pixel-width count of pixels, add into the accumulator.
// RULE10: average line-count lines of black levels to form the DAC code.
// RULE11: sync glitch filter ignores transitions within 100 ns of accepted edge.
// RULE12: fine field holds two DAC bits per channel, used only in manual mode.
// RULE13: new DAC code applies only after a measurement window ends; with loop off, code_q follows the offset and fine registers every clock.
`ifndef BLACK_LEVEL_CONSTS_SVH
`define BLACK_LEVEL_CONSTS_SVH

// -------------------------------------------------------------
// register indexes, byte address is four times the index
// -------------------------------------------------------------
`define IDX_CLAMP_CTRL 8'h05
`define IDX_OFS_A 8'h09
`define IDX_OFS_B 8'h0A
`define IDX_OFS_C 8'h0B
`define IDX_FINE 8'h0C
`define IDX_START_LO 8'h14
`define IDX_START_HI 8'h15
`define IDX_LOOP_CFG 8'h17
`define IDX_CODE_A 8'h1D
`define IDX_CODE_B 8'h1E
`define IDX_CODE_C 8'h1F

// -------------------------------------------------------------
// field positions
// -------------------------------------------------------------
`define BIT_COAST_CLAMP 5
`define BIT_RANGE_HALF 0
`define BIT_LOOP_OFF 0
`define FLD_PIX_HI 3
`define FLD_PIX_LO 2
`define FLD_LINES_HI 6
`define FLD_LINES_LO 4

// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define RST_REG8 8'h00
`define RST_CODE 10'h200

// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define GLITCH_NS 100
`define GLITCH_CYC ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PIX_BASE_SHIFT 4

`endif

/* verilog/black_level_pkg.sv */
package black_level_pkg;
  typedef struct packed {
    logic [7:0] c;
    logic [7:0] b;
    logic [7:0] a;
  } pix3_t;
  typedef struct packed {
    logic [9:0] c;
    logic [9:0] b;
    logic [9:0] a;
  } code3_t;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_MEASURE} loop_state_t;
endpackage

/* verilog/black_level_offset_loop.sv */
`timescale 1ns/100ps
`include "black_level_consts.svh"
module black_level_offset_loop
  import black_level_pkg::*;
#(
  parameter logic [7:0] BLACK_TARGET = 8'h10
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic hsync_in,
  input wire logic coast_in,
  input wire pix3_t adc_in,
  output pix3_t data_out,
  output code3_t dac_code_out,
  output logic dac_range_half_out,
  output logic hsync_filt_out
);

  // -------------------------------------------------------------
  // functions
  // -------------------------------------------------------------
  function automatic logic [7:0] avg8(input logic [14:0] s,
                                      input logic [2:0] sh);
    logic [14:0] t;
    t = s >> sh;
    return t[7:0];
  endfunction

  function automatic logic [9:0] sat10(input logic signed [12:0] v);
    if (v < 13'sd0) begin
      return 10'h000;
    end else if (v > 13'sd1023) begin
      return 10'h3FF;
    end
    return v[9:0];
  endfunction

  // -------------------------------------------------------------
  // register file
  // -------------------------------------------------------------
  logic [2:0][7:0] ofs_q;
  logic [7:0] fine_q;
  logic [7:0] start_lo_q;
  logic [7:0] start_hi_q;
  logic [7:0] cfg_q;
  logic [7:0] clamp_q;
  logic wr_pend_q;
  logic [7:0] wr_idx_q;
  logic [2:0][9:0] code_q;

  wire addr_take = hsel_in & htrans_in[1] & hready_in;
  wire [7:0] a_idx = haddr_in[9:2];
  wire a_hi_zero = (haddr_in[31:10] == 22'h0);
  wire [7:0] wbyte = hwdata_in[7:0];

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (a_hi_zero) begin
      unique case (a_idx)
        `IDX_CLAMP_CTRL: rd_mux = {24'h0, clamp_q};
        `IDX_OFS_A: rd_mux = {24'h0, ofs_q[0]};
        `IDX_OFS_B: rd_mux = {24'h0, ofs_q[1]};
        `IDX_OFS_C: rd_mux = {24'h0, ofs_q[2]};
        `IDX_FINE: rd_mux = {24'h0, fine_q};
        `IDX_START_LO: rd_mux = {24'h0, start_lo_q};
        `IDX_START_HI: rd_mux = {24'h0, start_hi_q};
        `IDX_LOOP_CFG: rd_mux = {24'h0, cfg_q};
        `IDX_CODE_A: rd_mux = {22'h0, code_q[0]};
        `IDX_CODE_B: rd_mux = {22'h0, code_q[1]};
        `IDX_CODE_C: rd_mux = {22'h0, code_q[2]};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // zero-wait slave: read data is latched in the address phase
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      hreadyout_out <= 1'b0;
      hresp_out <= 1'b0;
      hrdata_out <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      wr_pend_q <= addr_take & hwrite_in & a_hi_zero;
      wr_idx_q <= a_idx;
      if (addr_take & ~hwrite_in) begin
        hrdata_out <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ofs_q <= '0;
      fine_q <= `RST_REG8;
      start_lo_q <= `RST_REG8;
      start_hi_q <= `RST_REG8;
      cfg_q <= `RST_REG8;
      clamp_q <= `RST_REG8;
    end else if (wr_pend_q) begin
      unique case (wr_idx_q)
        `IDX_CLAMP_CTRL: clamp_q <= wbyte;
        `IDX_OFS_A: ofs_q[0] <= wbyte;
        `IDX_OFS_B: ofs_q[1] <= wbyte;
        `IDX_OFS_C: ofs_q[2] <= wbyte;
        `IDX_FINE: fine_q <= wbyte;
        `IDX_START_LO: start_lo_q <= wbyte;
        `IDX_START_HI: start_hi_q <= wbyte;
        `IDX_LOOP_CFG: cfg_q <= wbyte;
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------
  // config decode
  // -------------------------------------------------------------
  wire loop_off = cfg_q[`BIT_LOOP_OFF];
  wire range_half = fine_q[`BIT_RANGE_HALF];
  wire coast_clamp = clamp_q[`BIT_COAST_CLAMP];
  wire [1:0] pix_fld = cfg_q[`FLD_PIX_HI:`FLD_PIX_LO];
  wire [2:0] line_fld = cfg_q[`FLD_LINES_HI:`FLD_LINES_LO];
  wire [2:0] pix_shift = 3'(`PIX_BASE_SHIFT) + {1'b0, pix_fld};
  wire [15:0] start_cnt = {start_hi_q, start_lo_q};
  wire [15:0] pix_last = (16'h0001 << pix_shift) - 16'h0001;
  wire [7:0] line_last = (8'h01 << line_fld) - 8'h01;

  // -------------------------------------------------------------
  // hsync synchroniser and glitch filter
  // -------------------------------------------------------------
  logic hs_s1_q;
  logic hs_s2_q;
  logic hs_s3_q;
  logic hs_filt_q;
  logic [7:0] lock_q;
  localparam logic [7:0] LOCK_CYC = 8'(`GLITCH_CYC);

  // a level counts only once the second and third stages agree
  wire hs_agree = (hs_s2_q == hs_s3_q);
  wire hs_accept = hs_agree & (hs_s3_q != hs_filt_q) & (lock_q == 8'h00);
  // active-high sync assumed: trailing edge is the falling edge
  wire trail_edge = hs_accept & hs_filt_q;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      hs_s1_q <= 1'b0;
      hs_s2_q <= 1'b0;
      hs_s3_q <= 1'b0;
      hs_filt_q <= 1'b0;
      lock_q <= 8'h00;
    end else begin
      hs_s1_q <= hsync_in;
      hs_s2_q <= hs_s1_q;
      hs_s3_q <= hs_s2_q;
      // RULE11: lockout after accepted edge
      if (hs_accept) begin
        hs_filt_q <= hs_s3_q;
        lock_q <= LOCK_CYC;
      end else if (lock_q != 8'h00) begin
        lock_q <= lock_q - 8'h01;
      end
    end
  end

  // -------------------------------------------------------------
  // measurement sequencer
  // -------------------------------------------------------------
  loop_state_t state_q;
  logic [15:0] cnt_q;
  logic [7:0] lines_q;
  logic [2:0][14:0] pix_sum_q;
  logic [2:0][14:0] line_sum_q;

  // RULE7: coasting lines are not measured unless clamp bit set
  wire coast_block = coast_in & ~coast_clamp;
  // RULE6: one run per line, loop enabled only
  wire line_start = trail_edge & ~loop_off & ~coast_block;
  wire pix_done = (state_q == ST_MEASURE) & (cnt_q == pix_last);
  wire lines_done = pix_done & (lines_q == line_last);
  wire [2:0][7:0] adc_arr = adc_in;

  logic [2:0][14:0] pix_total;
  logic [2:0][14:0] line_total;
  logic [2:0][9:0] auto_code;
  logic [2:0][9:0] man_code;
  logic [2:0][7:0] data_d;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ch
      wire [7:0] line_avg;
      wire [7:0] blk_avg;
      wire signed [8:0] err;
      wire signed [12:0] step;
      wire signed [9:0] dsum;
      assign pix_total[g] = pix_sum_q[g] + {7'h00, adc_arr[g]};
      // RULE9: per-line average of the window
      assign line_avg = avg8(pix_total[g], pix_shift);
      assign line_total[g] = line_sum_q[g] + {7'h00, line_avg};
      // RULE10: average over the selected line count
      assign blk_avg = avg8(line_total[g], line_fld);
      assign err = $signed({1'b0, blk_avg}) - $signed({1'b0, BLACK_TARGET});
      // RULE4: eight steps per ADC LSB reduced, four by default
      assign step = range_half ? (13'(err) <<< 3) : (13'(err) <<< 2);
      // RULE5: move the code against the measured error
      assign auto_code[g] = sat10($signed({3'b000, code_q[g]}) - step);
      // RULE12: fine bits per channel, a at [7:6], b [5:4], c [3:2]
      assign man_code[g] = {ofs_q[g], fine_q[7 - 2 * g -: 2]};
      // RULE1: signed user offset added to the sample, clipped
      assign dsum = $signed({2'b00, adc_arr[g]})
                  + $signed({{2{ofs_q[g][7]}}, ofs_q[g]});
      assign data_d[g] = loop_off ? adc_arr[g] :
                         dsum[9] ? 8'h00 :
                         dsum[8] ? 8'hFF : dsum[7:0];
    end
  endgenerate

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      pix_sum_q <= '0;
    end else if (line_start) begin
      state_q <= ST_DELAY;
      cnt_q <= 16'h0000;
    end else if (loop_off | coast_block) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: ;
        // RULE8: wait start-pixel clocks before the window
        ST_DELAY: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == start_cnt) begin
            state_q <= ST_MEASURE;
            cnt_q <= 16'h0000;
            pix_sum_q <= '0;
          end
        end
        ST_MEASURE: begin
          cnt_q <= cnt_q + 16'h0001;
          pix_sum_q <= pix_total;
          if (pix_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      lines_q <= 8'h00;
      line_sum_q <= '0;
    end else if (loop_off) begin
      lines_q <= 8'h00;
      line_sum_q <= '0;
    end else if (pix_done & ~line_start & ~coast_block) begin
      if (lines_done) begin
        lines_q <= 8'h00;
        line_sum_q <= '0;
      end else begin
        lines_q <= lines_q + 8'h01;
        line_sum_q <= line_total;
      end
    end
  end

  // -------------------------------------------------------------
  // dac code and outputs
  // -------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      code_q <= {3{`RST_CODE}};
    end else if (loop_off) begin
      // RULE2: manual code straight from software
      code_q <= man_code;
    end else if (lines_done & ~line_start & ~coast_block) begin
      // RULE13: update only as the window closes
      code_q <= auto_code;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      data_out <= '0;
      dac_code_out <= {3{`RST_CODE}};
      dac_range_half_out <= 1'b0;
      hsync_filt_out <= 1'b0;
    end else begin
      data_out <= data_d;
      dac_code_out <= code_q;
      // RULE3: analogue swing halved in both modes
      dac_range_half_out <= range_half;
      hsync_filt_out <= hs_filt_q;
    end
  end

endmodule

/* testbench/black_level_asserts.sv */
`timescale 1ns/100ps
`include "black_level_consts.svh"
module black_level_asserts
  import black_level_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic [31:0] hrdata_out,
  input wire pix3_t adc_in,
  input wire pix3_t data_out,
  input wire code3_t dac_code_out,
  input wire logic hsync_filt_out
);
  // ------------------------------------------
  // shadow of the loop-off bit
  // ------------------------------------------
  logic wr_d;
  logic rd_d;
  logic wr_q;
  logic off_q;
  logic [7:0] idx_q;
  logic [7:0] since_q;
  assign wr_d = hsel_in && htrans_in[1] && hready_in && hwrite_in;
  assign rd_d = hsel_in && htrans_in[1] && hready_in && !hwrite_in;
  always_ff @(posedge mclk_in) idx_q <= haddr_in[9:2];
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wr_q <= 1'b0;
      off_q <= 1'b0;
      since_q <= 8'h00;
    end else begin
      wr_q <= wr_d;
      if (wr_q && idx_q == `IDX_LOOP_CFG) off_q <= hwdata_in[0];
      // saturates so that long idle spans never wrap
      if ($fell(hsync_filt_out)) since_q <= 8'h00;
      else if (since_q != 8'hFF) since_q <= since_q + 8'h01;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  a_code_reset: assert property (
    $past(reset_in) |-> dac_code_out == {3{`RST_CODE}})
    else $error("dac code not at midscale after reset");
  a_ready_high: assert property (!$past(reset_in) |-> hreadyout_out)
    else $error("bus ready dropped");
  a_filt_lockout: assert property (
    $changed(hsync_filt_out) |=> $stable(hsync_filt_out)[*8])
    else $error("sync filter changed inside lockout");
  a_bypass_off: assert property (
    off_q |=> data_out == $past(adc_in))
    else $error("samples altered with loop off");
  a_manual_hold: assert property (
    off_q && $past(off_q, 4) && !$past(wr_q) && !$past(wr_q, 2)
    && !$past(wr_q, 3) |-> $stable(dac_code_out))
    else $error("manual dac code moved without a write");
  a_rdata_cause: assert property ($changed(hrdata_out) |-> $past(rd_d))
    else $error("read data changed without a read");
  a_rdata_upper: assert property (hrdata_out[31:10] == 22'h0)
    else $error("upper read data bits set");
  a_code_late: assert property (
    $changed(dac_code_out) && !off_q && !$past(off_q, 4)
    |-> since_q > 8'd12)
    else $error("loop code changed inside a window");
  c_manual: cover property (off_q && $changed(dac_code_out));
  c_loop: cover property (!off_q && $changed(dac_code_out));
  c_filt: cover property ($fell(hsync_filt_out));
endmodule
bind black_level_offset_loop black_level_asserts i_black_level_asserts (
  .mclk_in, .reset_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
  .hwdata_in, .hready_in, .hreadyout_out, .hrdata_out, .adc_in,
  .data_out, .dac_code_out, .hsync_filt_out);

/* testbench/testbench.sv */
`timescale 1ns/100ps
`include "black_level_consts.svh"
module testbench
  import black_level_pkg::*;
;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [31:0] hwdata_in = 32'h0;
  logic hsync_in = 1'b0;
  logic coast_in = 1'b0;
  pix3_t adc_in = 24'h0;
  wire logic hreadyout_out;
  wire logic [31:0] hrdata_out;
  wire logic hresp_out;
  pix3_t data_out;
  code3_t dac_code_out;
  logic dac_range_half_out;
  logic hsync_filt_out;
  integer n_fail = 0;
  integer comparisons = 0;
  always #5 mclk_in = ~mclk_in;
  black_level_offset_loop i_black_level_offset_loop (
    .mclk_in(mclk_in), .reset_in(reset_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(3'h2), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .hrdata_out(hrdata_out),
    .hsync_in(hsync_in), .coast_in(coast_in), .adc_in(adc_in),
    .data_out(data_out), .dac_code_out(dac_code_out),
    .dac_range_half_out(dac_range_half_out),
    .hsync_filt_out(hsync_filt_out));
  task automatic results;
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ix,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    hwrite_in <= w;
    haddr_in <= {22'h0, ix, 2'h0};
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask
  task automatic wr(input logic [7:0] ix, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, ix, d, t);
  endtask
  task automatic rchk(input logic [7:0] ix, input logic [31:0] e);
    logic [31:0] t;
    bus(1'b0, ix, 32'h0, t);
    chk("register", e, t);
    chk("response", 32'h0, {31'h0, hresp_out});
  endtask
  task automatic cchk(input logic [29:0] e, input int wait_cyc);
    repeat (wait_cyc) @(posedge mclk_in);
    chk("dac code", {2'h0, e}, {2'h0, dac_code_out});
  endtask
  // one line: a short glitch right after the leading edge
  task automatic hline;
    hsync_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    hsync_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    hsync_in <= 1'b1;
    // an unfiltered glitch would show low here
    repeat (4) @(posedge mclk_in);
    chk("sync filter", 32'h1, {31'h0, hsync_filt_out});
    repeat (10) @(posedge mclk_in);
    chk("sync filter", 32'h1, {31'h0, hsync_filt_out});
    hsync_in <= 1'b0;
  endtask
  task automatic t_reset;
    rchk(`IDX_LOOP_CFG, 32'h0);
    rchk(`IDX_FINE, 32'h0);
    rchk(`IDX_CODE_B, {22'h0, `RST_CODE});
  endtask
  task automatic t_loop;
    adc_in <= {3{8'h18}};
    wr(`IDX_START_LO, 32'h02);
    hline;
    cchk({3{`RST_CODE}}, 6);
    cchk({3{10'h1E0}}, 60);
    coast_in <= 1'b1;
    adc_in <= {3{8'h14}};
    hline;
    cchk({3{10'h1E0}}, 66);
    coast_in <= 1'b0;
    wr(`IDX_FINE, 32'h01);
    hline;
    cchk({3{10'h1C0}}, 66);
    chk("range", 32'h1, {31'h0, dac_range_half_out});
    // two lines of 32 pixels: code moves only after the second
    wr(`IDX_LOOP_CFG, 32'h14);
    adc_in <= {3{8'h18}};
    hline;
    cchk({3{10'h1C0}}, 80);
    adc_in <= {3{8'h20}};
    hline;
    cchk({3{10'h160}}, 80);
  endtask
  task automatic t_adder;
    wr(`IDX_OFS_A, 32'h05);
    wr(`IDX_OFS_B, 32'hFE);
    wr(`IDX_OFS_C, 32'h7F);
    adc_in <= 24'hF00110;
    repeat (3) @(posedge mclk_in);
    chk("samples", 32'hFF0015, {8'h0, data_out});
  endtask
  task automatic t_manual;
    wr(`IDX_LOOP_CFG, 32'h01);
    wr(`IDX_OFS_A, 32'hFFFFFF12);
    wr(`IDX_OFS_B, 32'h34);
    wr(`IDX_OFS_C, 32'h56);
    wr(`IDX_FINE, 32'hD8);
    cchk({10'h15A, 10'h0D1, 10'h04B}, 3);
    chk("range", 32'h0, {31'h0, dac_range_half_out});
    chk("samples", 32'hF00110, {8'h0, data_out});
    rchk(`IDX_OFS_A, 32'h12);
    wr(`IDX_CODE_A, 32'h3FF);
    rchk(`IDX_CODE_A, 32'h04B);
    wr(8'h30, 32'hFF);
    rchk(8'h30, 32'h0);
  endtask
  initial begin
    #20us;
    n_fail++;
    results;
  end
  initial begin
    repeat (2) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    t_reset;
    t_loop;
    t_adder;
    t_manual;
    results;
  end
endmodule
